// ==== logic/v23tc_top.sv ====
// V.23 rate selection, result echo and turnaround sequencing with APB regs
//
// Summary of operation
// RQ1: V.23 only for format xx10xx00 or xx01xx10
// RQ2: Reverse-transmit bit: send 75, receive fast
// RQ3: Reverse-receive bit: receive 75, send fast
// RQ4: Fast rate bit picks 1200, else 600
// RQ5: Connect sending fast, receiving 75: echo c
// RQ6: Connect sending 75, receiving fast: echo v
// RQ7: Master sends at 75; slave sends fast
// RQ8: Host escapes to command mode before turnaround
// RQ9: Host requests turnaround only while master
// RQ10: Reverse-online command starts turnaround, back online
// RQ11: Master: carrier to 1300, 390 found: c
// RQ12: Master 440 ms without 390: hang up, N
// RQ13: Slave: carrier drop over 20 ms reverses
// RQ14: Slave finds 1300: alert, next echo v
// RQ15: Else reverse again; 390 found: alert, c
// RQ16: Second check fails: hang up, alert, N
// RQ17: Master success or first slave check success updates both direction bits
// RQ18: Host sets pin-four function to alert
// RQ19: Ninth bit mirrors alert when so configured
// RQ20: Carrier time summed; win over 40 ms
`timescale 1ns/100ps
module v23tc_top
   import v23tc_pkg::*;
#(
   parameter int unsigned MASTER_WIN = v23tc_pkg::MASTER_WIN_CYC,
   parameter int unsigned SLAVE_WIN = v23tc_pkg::SLAVE_WIN_CYC,
   parameter int unsigned CARRIER_MIN = v23tc_pkg::CARRIER_MIN_CYC,
   parameter int unsigned DROP_MIN = v23tc_pkg::DROP_MIN_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic connect_in,
   input wire logic rx_carrier_390_in,
   input wire logic rx_carrier_1300_in,
   output logic [1:0] tx_rate_out,
   output logic [1:0] rx_rate_out,
   output logic tx_carrier_1300_out,
   output logic hangup_out,
   output logic echo_valid_out,
   output logic [7:0] echo_char_out,
   output logic alert_out,
   output logic ninth_bit_out
);
   import v23tc_pkg::*;

   if (CARRIER_MIN == 0 || DROP_MIN == 0 || CARRIER_MIN >= SLAVE_WIN ||
       CARRIER_MIN >= MASTER_WIN)
      $error("v23tc_top: carrier minimum must be nonzero and below windows");

   logic [7:0] modem_format_select;
   logic [3:0] config_bits;
   logic alert;
   logic [7:0] pending_char;
   logic pending_valid;
   v23tc_state_t state;
   logic [31:0] drop_cnt;
   logic win_start;
   logic win_carrier;
   logic [31:0] win_len;
   logic win_done;
   logic win_found;
   logic v23_enable;
   logic master;
   logic wr_access;
   logic mapped;
   logic cmd_reverse;
   logic cmd_release;
   logic cmd_alert_clr;
   logic drop_long;
   logic master_ok;
   logic master_fail;
   logic slave_fast_ok;
   logic slave_fast_fail;
   logic slave_slow_ok;
   logic slave_slow_fail;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode
   assign v23_enable =
      (modem_format_select[5:4] == 2'b10 &&
       modem_format_select[1:0] == 2'b00) ||
      (modem_format_select[5:4] == 2'b01 &&
       modem_format_select[1:0] == 2'b10); // [RQ1]
   assign master = v23_enable && modem_format_select[FMT_REV_TX]; // [RQ7]

   // APB decode; zero-wait slave, unmapped offsets answer with an error
   assign mapped = paddr_in == REG_FORMAT || paddr_in == REG_CONFIG ||
                   paddr_in == REG_COMMAND || paddr_in == REG_STATUS;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign wr_access = psel_in && penable_in && pwrite_in;
   assign cmd_reverse = wr_access && paddr_in == REG_COMMAND &&
                        pwdata_in[CMD_REVERSE];
   assign cmd_release = wr_access && paddr_in == REG_COMMAND &&
                        pwdata_in[CMD_RELEASE];
   assign cmd_alert_clr = wr_access && paddr_in == REG_COMMAND &&
                          pwdata_in[CMD_ALERT_CLR];

   // Window verdicts qualified by the step that launched the window
   assign master_ok = state == ST_MASTER_WAIT && win_done && win_found;
   assign master_fail = state == ST_MASTER_WAIT && win_done && !win_found;
   assign slave_fast_ok = state == ST_SLAVE_FAST && win_done && win_found;
   assign slave_fast_fail = state == ST_SLAVE_FAST && win_done && !win_found;
   assign slave_slow_ok = state == ST_SLAVE_SLOW && win_done && win_found;
   assign slave_slow_fail = state == ST_SLAVE_SLOW && win_done && !win_found;
   // Remote master sends on 390 Hz; its silence is the reversal cue
   assign drop_long = state == ST_DATA && v23_enable && !master &&
                      drop_cnt >= 32'(DROP_MIN); // [RQ13]

   ////////////////////////////////////////////////////////////////////////
   // Format register; hardware direction update wins over a software write
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         modem_format_select <= FORMAT_RESET;
      else if (master_ok)
      begin
         modem_format_select[FMT_REV_TX] <= 1'b0; // [RQ17]
         modem_format_select[FMT_REV_RX] <= 1'b1; // [RQ17]
      end
      else if (slave_fast_ok)
      begin
         modem_format_select[FMT_REV_TX] <= 1'b1; // [RQ17]
         modem_format_select[FMT_REV_RX] <= 1'b0; // [RQ17]
      end
      else if (wr_access && paddr_in == REG_FORMAT)
         modem_format_select <= pwdata_in[7:0];
   end

   // Config register: ninth-bit options and pin-four function
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         config_bits <= CONFIG_RESET;
      else if (wr_access && paddr_in == REG_CONFIG)
         config_bits <= pwdata_in[3:0];
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         prdata_out <= '0;
      else if (psel_in && !penable_in)
      begin
         case (paddr_in)
            REG_FORMAT: prdata_out <= {24'h0, modem_format_select};
            REG_CONFIG: prdata_out <= {28'h0, config_bits};
            REG_STATUS: prdata_out <= {16'h0, pending_char, 2'h0,
                                       pending_valid, alert, state,
                                       master, v23_enable};
            default: prdata_out <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Carrier-drop timer, only meaningful while slave and online
   always_ff @(posedge core_clk_in)
   begin
      // Held clear while V.23 is off, or enabling would look like a drop
      if (rst_in || state != ST_DATA || rx_carrier_390_in || master ||
          !v23_enable)
         drop_cnt <= '0;
      else if (drop_cnt < 32'(DROP_MIN))
         drop_cnt <= drop_cnt + 1'b1;
   end

   // Turnaround sequencer
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         state <= ST_DATA;
      else
      begin
         case (state)
            ST_DATA:
               // A request while slave is ignored; the host must not send it
               if (cmd_reverse && master) // [RQ10] [RQ9]
                  state <= ST_MASTER_WAIT;
               else if (drop_long)
                  state <= ST_SLAVE_FAST; // [RQ13]
            ST_MASTER_WAIT:
               if (win_done)
                  state <= ST_DATA;
            ST_SLAVE_FAST:
               if (slave_fast_fail)
                  state <= ST_SLAVE_SLOW; // [RQ15]
               else if (win_done)
                  state <= ST_DATA;
            ST_SLAVE_SLOW:
               if (win_done)
                  state <= ST_DATA;
            default: state <= ST_DATA;
         endcase
      end
   end

   // Window launch and what it listens for in each step
   assign win_start = (state == ST_DATA && cmd_reverse && master) ||
                      drop_long || slave_fast_fail;
   always_comb
   begin
      win_carrier = rx_carrier_390_in;
      win_len = 32'(SLAVE_WIN);
      if (state == ST_MASTER_WAIT || (state == ST_DATA && !drop_long))
         win_len = 32'(MASTER_WIN); // [RQ11]
      if (drop_long || state == ST_SLAVE_FAST)
         win_carrier = rx_carrier_1300_in; // [RQ14]
   end

   v23tc_window #(
      .WIDTH(32)
   ) u_window (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .start_in(win_start),
      .carrier_in(win_carrier),
      .window_cyc_in(win_len),
      .min_cyc_in(32'(CARRIER_MIN)),
      .done_out(win_done),
      .found_out(win_found)
   );

   ////////////////////////////////////////////////////////////////////////
   // Line-side outputs: rates, carrier tone, hang-up pulse
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || !v23_enable)
      begin
         tx_rate_out <= RATE_OFF;
         rx_rate_out <= RATE_OFF;
      end
      else if (modem_format_select[FMT_REV_TX])
      begin
         tx_rate_out <= RATE_75; // [RQ2]
         rx_rate_out <= modem_format_select[FMT_FAST_1200] ?
                        RATE_1200 : RATE_600; // [RQ4]
      end
      else
      begin
         rx_rate_out <= RATE_75; // [RQ3]
         tx_rate_out <= modem_format_select[FMT_FAST_1200] ?
                        RATE_1200 : RATE_600; // [RQ4]
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         tx_carrier_1300_out <= 1'b0;
         hangup_out <= 1'b0;
      end
      else
      begin
         hangup_out <= master_fail || slave_slow_fail; // [RQ12] [RQ16]
         case (state)
            ST_MASTER_WAIT: tx_carrier_1300_out <= 1'b1; // [RQ11]
            ST_SLAVE_FAST: tx_carrier_1300_out <= 1'b0; // [RQ13]
            ST_SLAVE_SLOW: tx_carrier_1300_out <= 1'b1; // [RQ15]
            default: tx_carrier_1300_out <= v23_enable && !master; // [RQ7]
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host echo: immediate results, or a slave result held until released
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         echo_valid_out <= 1'b0;
         echo_char_out <= 8'h00;
      end
      else
      begin
         echo_valid_out <= 1'b0;
         if (connect_in && v23_enable)
         begin
            echo_valid_out <= 1'b1;
            echo_char_out <= master ? CHAR_V : CHAR_C; // [RQ5] [RQ6]
         end
         else if (master_ok || master_fail)
         begin
            echo_valid_out <= 1'b1;
            echo_char_out <= master_ok ? CHAR_C : CHAR_N; // [RQ11] [RQ12]
         end
         else if (cmd_release && pending_valid)
         begin
            echo_valid_out <= 1'b1;
            echo_char_out <= pending_char;
         end
      end
   end

   // Slave result; a new verdict overrides a release in the same cycle
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pending_valid <= 1'b0;
         pending_char <= 8'h00;
      end
      else if (slave_fast_ok || slave_slow_ok || slave_slow_fail)
      begin
         pending_valid <= 1'b1;
         pending_char <= slave_fast_ok ? CHAR_V : // [RQ14]
                         slave_slow_ok ? CHAR_C : CHAR_N; // [RQ15] [RQ16]
      end
      else if (cmd_release && !(connect_in && v23_enable) &&
               !master_ok && !master_fail)
         pending_valid <= 1'b0;
   end

   // Sticky alert; a set in the clear cycle wins
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         alert <= 1'b0;
      else if (slave_fast_ok || slave_slow_ok || slave_slow_fail)
         alert <= 1'b1; // [RQ14] [RQ15] [RQ16]
      else if (cmd_alert_clr)
         alert <= 1'b0;
   end

   // Pin four carries alert only when the host selected that function
   assign alert_out = alert &&
      config_bits[CFG_PIN4_LO+1:CFG_PIN4_LO] == PIN4_ALERT; // [RQ18]
   assign ninth_bit_out = alert && config_bits[CFG_NINTH_EN] &&
                          !config_bits[CFG_NINTH_FRAME]; // [RQ19]

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_master_request;
      state == ST_DATA && cmd_reverse && master;
   endsequence
   sequence s_in_master_wait;
      state == ST_MASTER_WAIT && tx_carrier_1300_out;
   endsequence

   property p_v23_gate;
      @(posedge core_clk_in) disable iff (rst_in)
      !v23_enable |=> tx_rate_out == RATE_OFF && rx_rate_out == RATE_OFF;
   endproperty
   a_v23_gate: assert property (p_v23_gate) // [RQ1]
      else $error("rates active with V.23 disabled");

   property p_rev_tx_rates;
      @(posedge core_clk_in) disable iff (rst_in)
      v23_enable && modem_format_select[FMT_REV_TX] |=>
         tx_rate_out == RATE_75 && rx_rate_out != RATE_75;
   endproperty
   a_rev_tx_rates: assert property (p_rev_tx_rates) // [RQ2]
      else $error("reverse-transmit rates wrong");

   property p_fast_rate;
      @(posedge core_clk_in) disable iff (rst_in)
      v23_enable && !modem_format_select[FMT_REV_TX] &&
      !modem_format_select[FMT_FAST_1200] |=> tx_rate_out == RATE_600;
   endproperty
   a_fast_rate: assert property (p_fast_rate) // [RQ4]
      else $error("fast channel not at 600");

   property p_connect_echo;
      @(posedge core_clk_in) disable iff (rst_in)
      connect_in && v23_enable && !master |=>
         echo_valid_out && echo_char_out == CHAR_C;
   endproperty
   a_connect_echo: assert property (p_connect_echo) // [RQ5]
      else $error("connect did not echo c");

   property p_master_start;
      @(posedge core_clk_in) disable iff (rst_in)
      s_master_request ##1 !win_done |=> s_in_master_wait;
   endproperty
   a_master_start: assert property (p_master_start) // [RQ10] [RQ11]
      else $error("turnaround did not start on 1300 Hz");

   property p_master_fail;
      @(posedge core_clk_in) disable iff (rst_in)
      master_fail |=> hangup_out && echo_valid_out &&
         echo_char_out == CHAR_N ##1 !hangup_out;
   endproperty
   a_master_fail: assert property (p_master_fail) // [RQ12]
      else $error("master failure did not hang up with N");

   property p_master_swap;
      @(posedge core_clk_in) disable iff (rst_in)
      master_ok |=> !modem_format_select[FMT_REV_TX] &&
         modem_format_select[FMT_REV_RX] && state == ST_DATA;
   endproperty
   a_master_swap: assert property (p_master_swap) // [RQ17]
      else $error("direction bits not swapped after master turnaround");

   property p_slave_reverse;
      @(posedge core_clk_in) disable iff (rst_in)
      drop_long |=> state == ST_SLAVE_FAST ##1 !tx_carrier_1300_out;
   endproperty
   a_slave_reverse: assert property (p_slave_reverse) // [RQ13]
      else $error("carrier drop did not reverse to 390 Hz");

   property p_slave_retry;
      @(posedge core_clk_in) disable iff (rst_in)
      slave_fast_fail |=> state == ST_SLAVE_SLOW && !alert_out[*1];
   endproperty
   a_slave_retry: assert property (p_slave_retry) // [RQ15]
      else $error("first slave failure did not retry");

   property p_slave_result;
      @(posedge core_clk_in) disable iff (rst_in)
      slave_fast_ok |=> alert && pending_valid && pending_char == CHAR_V;
   endproperty
   a_slave_result: assert property (p_slave_result) // [RQ14]
      else $error("slave success did not raise alert with v");

   property p_slave_fail;
      @(posedge core_clk_in) disable iff (rst_in)
      slave_slow_fail |=> hangup_out && alert && pending_char == CHAR_N;
   endproperty
   a_slave_fail: assert property (p_slave_fail) // [RQ16]
      else $error("second slave failure wrong");

   property p_ninth_bit;
      @(posedge core_clk_in) disable iff (rst_in)
      config_bits[CFG_NINTH_EN] && !config_bits[CFG_NINTH_FRAME] |->
         ninth_bit_out == alert;
   endproperty
   a_ninth_bit: assert property (p_ninth_bit) // [RQ19]
      else $error("ninth bit does not follow alert");
endmodule : v23tc_top

// ==== logic/v23tc_pkg.sv ====
// Shared constants for the V.23 turnaround controller
package v23tc_pkg;
   // APB register byte offsets
   localparam logic [7:0] REG_FORMAT = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h04;
   localparam logic [7:0] REG_COMMAND = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   // Reset values
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   localparam logic [3:0] CONFIG_RESET = 4'h0;
   // Bit positions in the format register
   localparam int FMT_REV_TX = 5;
   localparam int FMT_REV_RX = 4;
   localparam int FMT_FAST_1200 = 2;
   // Bit positions in the config register
   localparam int CFG_NINTH_EN = 0;
   localparam int CFG_NINTH_FRAME = 1;
   localparam int CFG_PIN4_LO = 2;
   localparam logic [1:0] PIN4_ALERT = 2'b11;
   // Bit positions in the command register
   localparam int CMD_REVERSE = 0;
   localparam int CMD_RELEASE = 1;
   localparam int CMD_ALERT_CLR = 2;
   // Rate codes on the rate outputs
   localparam logic [1:0] RATE_OFF = 2'h0;
   localparam logic [1:0] RATE_75 = 2'h1;
   localparam logic [1:0] RATE_600 = 2'h2;
   localparam logic [1:0] RATE_1200 = 2'h3;
   // Result characters
   localparam logic [7:0] CHAR_C = 8'h63;
   localparam logic [7:0] CHAR_V = 8'h76;
   localparam logic [7:0] CHAR_N = 8'h4e;
   // Timing, in ms as printed, and derived cycle counts at 100 MHz
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned MASTER_WIN_MS = 440;
   localparam int unsigned SLAVE_WIN_MS = 220;
   localparam int unsigned CARRIER_MIN_MS = 40;
   localparam int unsigned DROP_MIN_MS = 20;
   localparam int unsigned MASTER_WIN_CYC = MASTER_WIN_MS * CYC_PER_MS;
   localparam int unsigned SLAVE_WIN_CYC = SLAVE_WIN_MS * CYC_PER_MS;
   localparam int unsigned CARRIER_MIN_CYC = CARRIER_MIN_MS * CYC_PER_MS;
   localparam int unsigned DROP_MIN_CYC = DROP_MIN_MS * CYC_PER_MS;
   // Turnaround sequencer states
   typedef enum logic [1:0] {
      ST_DATA = 2'b00,
      ST_MASTER_WAIT = 2'b01,
      ST_SLAVE_FAST = 2'b10,
      ST_SLAVE_SLOW = 2'b11
   } v23tc_state_t;
endpackage : v23tc_pkg

// ==== logic/v23tc_window.sv ====
// Carrier accumulation window: sums carrier time until threshold or expiry
`timescale 1ns/100ps
module v23tc_window #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic carrier_in,
   input wire logic [WIDTH-1:0] window_cyc_in,
   input wire logic [WIDTH-1:0] min_cyc_in,
   output logic done_out,
   output logic found_out
);
   import v23tc_pkg::*;

   logic running;
   logic [WIDTH-1:0] elapsed;
   logic [WIDTH-1:0] acc;
   logic hit;
   logic expire;

   // Presence need not be continuous: short fades pause the total but do not clear it
   assign hit = running && carrier_in && (acc >= min_cyc_in); // [RQ20]
   assign expire = running && !hit && (elapsed >= window_cyc_in - 1'b1);

   ////////////////////////////////////////////////////////////////////////
   // Window run flag and counters
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || start_in)
      begin
         running <= start_in;
         elapsed <= '0;
         acc <= '0;
      end
      else if (running)
      begin
         elapsed <= elapsed + 1'b1;
         if (carrier_in)
            acc <= acc + 1'b1; // [RQ20]
         if (hit || expire)
            running <= 1'b0;
      end
   end

   // One-cycle verdict; found marks the success case
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         done_out <= 1'b0;
         found_out <= 1'b0;
      end
      else
      begin
         done_out <= hit || expire;
         found_out <= hit;
      end
   end

   property p_found_needs_time;
      @(posedge core_clk_in) disable iff (rst_in)
      hit |-> acc >= min_cyc_in;
   endproperty
   a_found_needs_time: assert property (p_found_needs_time) // [RQ20]
      else $error("window success before enough carrier time");
endmodule : v23tc_window

// ==== test/v23tc_remote.sv ====
// Remote modem model: answers on the band opposite to our carrier
`timescale 1ns/100ps
module v23tc_remote (
   input wire logic core_clk_in,
   input wire logic our_1300_in,
   input wire logic slow_en_in,
   input wire logic fast_en_in,
   input wire logic [7:0] lag_in,
   output logic carrier_390_out,
   output logic carrier_1300_out
);
   logic [7:0] cnt_slow = 8'h00;
   logic [7:0] cnt_fast = 8'h00;
   logic want_slow;
   logic want_fast;
   // A modem never answers on the band it hears us on
   assign want_slow = slow_en_in && our_1300_in;
   assign want_fast = fast_en_in && !our_1300_in;
   // Lag counters let the bench pick a prompt or a slow answer
   always_ff @(posedge core_clk_in)
   begin
      cnt_slow <= !want_slow ? 8'h00 : cnt_slow + {7'h0, cnt_slow != 8'hff};
      cnt_fast <= !want_fast ? 8'h00 : cnt_fast + {7'h0, cnt_fast != 8'hff};
   end
   assign carrier_390_out = want_slow && cnt_slow >= lag_in;
   assign carrier_1300_out = want_fast && cnt_fast >= lag_in;
endmodule : v23tc_remote

// ==== test/v23tc_bench.sv ====
// Self-checking bench for the V.23 turnaround controller
`timescale 1ns/100ps
module v23tc_bench;
   import v23tc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, conn = 1'b0, rx390, rx1300, tx1300, hangup;
   logic [1:0] tx_rate, rx_rate;
   logic echo_v, alert, ninth, slow_en = 1'b0, fast_en = 1'b0;
   logic [7:0] echo_c;
   logic [7:0] lag = 8'h05;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h37;
   int num_errors = 0;
   int check_count = 0;
   int hangups = 0;
   ////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   v23tc_top #(.MASTER_WIN(200), .SLAVE_WIN(100), .CARRIER_MIN(20),
      .DROP_MIN(10)) u_dut (.core_clk_in(clk), .rst_in(rst),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .connect_in(conn),
      .rx_carrier_390_in(rx390), .rx_carrier_1300_in(rx1300),
      .tx_rate_out(tx_rate), .rx_rate_out(rx_rate),
      .tx_carrier_1300_out(tx1300), .hangup_out(hangup),
      .echo_valid_out(echo_v), .echo_char_out(echo_c),
      .alert_out(alert), .ninth_bit_out(ninth));
   v23tc_remote u_remote (.core_clk_in(clk), .our_1300_in(tx1300),
      .slow_en_in(slow_en), .fast_en_in(fast_en), .lag_in(lag),
      .carrier_390_out(rx390), .carrier_1300_out(rx1300));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want)
      begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   // Waits either for the echo notes to drain or for the alert
   task automatic wait_for(input int kind);
      int n;
      n = 0;
      while (n < 2000 && (kind == 0 ? exp_q.size() != 0 : alert !== 1'b1))
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000)
      begin
         num_errors++;
         $display("[ERR] %0t wait timed out", $time);
         give_verdict;
      end
   endtask : wait_for
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         num_errors++;
         $display("[ERR] %0t no pready", $time);
         give_verdict;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, want);
   endtask : rd
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      slow_en <= 1'b0;
      fast_en <= 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////
   // Monitor: each echo takes the oldest note off the queue
   always @(posedge clk)
   begin
      if (echo_v === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk({24'h0, echo_c}, 32'hffff);
         else
            chk({24'h0, echo_c}, {24'h0, exp_q.pop_front()});
      end
      if (hangup === 1'b1)
         hangups++;
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] q;
      logic e;
      logic [7:0] f;
      logic [1:0] fr;
      logic en;
      int h;
      do_reset;
      rd(REG_FORMAT, 32'h0);
      rd(REG_CONFIG, 32'h0);
      rd(REG_STATUS, 32'h0);
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      $display("register test done");
      // Two legal patterns and a random one; x bits are random
      for (int i = 0; i < 12; i++)
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         f = seed[7:0];
         if (i % 3 == 0)
            f = {f[7:6], 2'b10, f[3:2], 2'b00};
         if (i % 3 == 1)
            f = {f[7:6], 2'b01, f[3:2], 2'b10};
         en = (f[5:4] == 2'b10 && f[1:0] == 2'b00) ||
            (f[5:4] == 2'b01 && f[1:0] == 2'b10);
         fr = f[2] ? RATE_1200 : RATE_600;
         wr(REG_FORMAT, {24'h0, f});
         rd(REG_FORMAT, {24'h0, f});
         apb(1'b0, REG_STATUS, 32'h0, q, e);
         chk(q & 32'h3, {30'h0, f[5] & en, en});
         if (en)
         begin
            chk({30'h0, tx_rate}, {30'h0, f[5] ? RATE_75 : fr});
            chk({30'h0, rx_rate}, {30'h0, f[5] ? fr : RATE_75});
         end
      end
      $display("format test done");
      for (int i = 0; i < 2; i++)
      begin
         do_reset;
         wr(REG_FORMAT, i ? 32'h16 : 32'h20);
         exp_q.push_back(i ? CHAR_C : CHAR_V);
         conn <= 1'b1;
         @(posedge clk);
         conn <= 1'b0;
         wait_for(0);
      end
      $display("connect test done");
      // Master turnaround: remote answers, then stays silent
      for (int i = 0; i < 2; i++)
      begin
         do_reset;
         slow_en <= (i == 0);
         wr(REG_FORMAT, 32'h24);
         h = hangups;
         exp_q.push_back(i ? CHAR_N : CHAR_C);
         wr(REG_COMMAND, 32'h1);
         repeat (3) @(posedge clk);
         chk({31'h0, tx1300}, 32'h1);
         wait_for(0);
         rd(REG_FORMAT, i ? 32'h24 : 32'h14);
         chk(hangups - h, i);
      end
      $display("master test done");
      // Slave: 1300 found, 390 found on second try, nothing found
      for (int i = 0; i < 3; i++)
      begin
         do_reset;
         fast_en <= (i == 0);
         slow_en <= 1'b1;
         lag <= 8'h04;
         wr(REG_CONFIG, 32'hd);
         wr(REG_FORMAT, 32'h16);
         h = hangups;
         repeat (20) @(posedge clk);
         slow_en <= 1'b0;
         repeat (15) @(posedge clk);
         chk({31'h0, tx1300}, 32'h0);
         repeat (15) @(posedge clk);
         slow_en <= (i == 1);
         wait_for(1);
         // Remote carrier back, so a hung-up slave sees no fresh drop
         slow_en <= 1'b1;
         chk({30'h0, alert, ninth}, 32'h3);
         rd(REG_FORMAT, i ? 32'h16 : 32'h26);
         f = i == 0 ? CHAR_V : (i == 1 ? CHAR_C : CHAR_N);
         exp_q.push_back(f);
         wr(REG_COMMAND, 32'h2);
         wait_for(0);
         chk(hangups - h > 0, i == 2);
         wr(REG_FORMAT, 32'h0);
         wr(REG_COMMAND, 32'h4);
         rd(REG_STATUS, {16'h0, f, 8'h0});
         chk({30'h0, alert, ninth}, 32'h0);
      end
      $display("slave test done");
      give_verdict;
   end
endmodule : v23tc_bench
